//--- rtl/rai_consts.vh
// Purpose: constants for the isolated rs422/rs485 repeater control
// Assumes: 25 MHz reference clock
// Notes:   definitions only
`ifndef RAI_CONSTS_VH
`define RAI_CONSTS_VH

`define RAI_CLK_MHZ        25
`define RAI_HOLD_SHORT_US  10
`define RAI_HOLD_LONG_US   50
`define RAI_HOLD_SHORT_CYC (`RAI_HOLD_SHORT_US * `RAI_CLK_MHZ)
`define RAI_HOLD_LONG_CYC  (`RAI_HOLD_LONG_US * `RAI_CLK_MHZ)
`define RAI_CNT_W          11
`define RAI_IDLE_LEVEL     1'h1
`define RAI_STRAP_ON       1'h1

`endif

//--- rtl/rai_port_dir.v
// Purpose: automatic transmit enable for one rs485 port
// Assumes: data idles at mark (high); mode inputs static
// Notes:   hold counter restarts on every non-idle transmit sample
`timescale 1ns/1ps
`include "rai_consts.vh"

module rai_port_dir (
    input  wire       i_ref_clk,
    input  wire       i_rst,
    input  wire       i_mode_422,
    input  wire       i_mode_2w,
    input  wire       i_hold_short,
    input  wire       i_tx_data,
    output wire       o_drv_en,
    output wire       o_rcv_en
);
    localparam ST_IDLE = 2'h1;
    localparam ST_HOLD = 2'h2;
    // counts sized to the counter on purpose; both fit well below its range
    localparam [`RAI_CNT_W-1:0] HOLD_SHORT = `RAI_HOLD_SHORT_CYC;
    localparam [`RAI_CNT_W-1:0] HOLD_LONG  = `RAI_HOLD_LONG_CYC;

    reg [1:0]              state;
    reg [1:0]              next_state;
    reg [`RAI_CNT_W-1:0]   cnt;
    reg [`RAI_CNT_W-1:0]   next_cnt;
    reg                    drv;
    reg                    rcv;
    wire                   active;
    wire [`RAI_CNT_W-1:0]  hold_cyc;

    assign active   = (i_tx_data != `RAI_IDLE_LEVEL);
    assign hold_cyc = i_hold_short ? HOLD_SHORT
                                   : HOLD_LONG;

    always @* begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            ST_IDLE: begin
                if (active && !i_mode_422) begin
                    next_state = ST_HOLD;
                    next_cnt   = hold_cyc - 1'b1;
                end
            end
            ST_HOLD: begin
                if (i_mode_422) begin
                    next_state = ST_IDLE;
                end else if (active) begin
                    next_cnt = hold_cyc - 1'b1;
                end else if (cnt == {`RAI_CNT_W{1'b0}}) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            cnt   <= {`RAI_CNT_W{1'b0}};
            drv   <= 1'b0;
            rcv   <= 1'b1;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            // rs422 keeps both directions on regardless of activity
            drv   <= i_mode_422 | (next_state == ST_HOLD);
            // two-wire: receiver off for exactly as long as the driver is on
            rcv   <= i_mode_422 | !i_mode_2w
                     | (next_state != ST_HOLD);
        end
    end

    assign o_drv_en = drv;
    assign o_rcv_en = rcv;
endmodule // rai_port_dir

//--- rtl/rai_isolator.v
// Purpose: per-port control of an isolated rs422/rs485 repeater
// Assumes: line inputs synchronous to i_ref_clk, straps static, idle level high
// Notes:   one clock of latency on every forwarded line
`timescale 1ns/1ps
`include "rai_consts.vh"

module rai_isolator (
    input  wire i_ref_clk,
    input  wire i_rst,
    input  wire i_mode_strap_a,
    input  wire i_mode_strap_b,
    input  wire i_mode_strap_c,
    input  wire i_mode_strap_d,
    input  wire i_mode_strap_e,
    input  wire i_hold_time_strap_p0,
    input  wire i_hold_time_strap_p1,
    input  wire i_p0_rx_data,
    input  wire i_p0_rx_hs,
    input  wire i_p1_rx_data,
    input  wire i_p1_rx_hs,
    output wire o_p0_tx_data,
    output wire o_p0_tx_hs,
    output wire o_p0_drv_en,
    output wire o_p0_rcv_en,
    output wire o_p1_tx_data,
    output wire o_p1_tx_hs,
    output wire o_p1_drv_en,
    output wire o_p1_rcv_en,
    output wire o_strap_error
);
    reg  p0_tx_data;
    reg  p0_tx_hs;
    reg  p1_tx_data;
    reg  p1_tx_hs;
    reg  strap_err;
    wire mode_422;
    wire mode_2w;
    wire mode_4w;
    wire p0_drv;
    wire p0_rcv;
    wire p1_drv;
    wire p1_rcv;
    wire p0_rx_gated;
    wire p1_rx_gated;

    // strap b off means rs422 whatever a says; a on with b off is not a mode
    assign mode_422 = (i_mode_strap_b != `RAI_STRAP_ON);
    assign mode_2w  = (i_mode_strap_b == `RAI_STRAP_ON) &&
                      (i_mode_strap_a == `RAI_STRAP_ON);
    assign mode_4w  = !mode_422 && !mode_2w;

    // a disabled receiver reads as idle so nothing leaks to the far side
    assign p0_rx_gated = p0_rcv ? i_p0_rx_data : `RAI_IDLE_LEVEL;
    assign p1_rx_gated = p1_rcv ? i_p1_rx_data : `RAI_IDLE_LEVEL;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            p0_tx_data <= `RAI_IDLE_LEVEL;
            p0_tx_hs   <= `RAI_IDLE_LEVEL;
            p1_tx_data <= `RAI_IDLE_LEVEL;
            p1_tx_hs   <= `RAI_IDLE_LEVEL;
            strap_err  <= 1'b0;
        end else begin
            p0_tx_data <= p1_rx_gated;
            p1_tx_data <= p0_rx_gated;
            // handshake lines exist only in rs422
            p0_tx_hs   <= mode_422 ? i_p1_rx_hs : `RAI_IDLE_LEVEL;
            p1_tx_hs   <= mode_422 ? i_p0_rx_hs : `RAI_IDLE_LEVEL;
            strap_err  <= (i_mode_strap_a == `RAI_STRAP_ON && mode_422)
                          || (i_mode_strap_c == `RAI_STRAP_ON)
                          || (i_mode_strap_d != `RAI_STRAP_ON)
                          || (i_mode_strap_e == `RAI_STRAP_ON);
        end
    end

    // port 0 transmits what port 1 received, and vice versa
    rai_port_dir u_dir_p0 (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_mode_422   (mode_422),
        .i_mode_2w    (mode_2w),
        .i_hold_short (i_hold_time_strap_p0),
        .i_tx_data    (p1_rx_gated),
        .o_drv_en     (p0_drv),
        .o_rcv_en     (p0_rcv)
    );

    rai_port_dir u_dir_p1 (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_mode_422   (mode_422),
        .i_mode_2w    (mode_2w),
        .i_hold_short (i_hold_time_strap_p1),
        .i_tx_data    (p0_rx_gated),
        .o_drv_en     (p1_drv),
        .o_rcv_en     (p1_rcv)
    );

    assign o_p0_tx_data  = p0_tx_data;
    assign o_p0_tx_hs    = p0_tx_hs;
    assign o_p0_drv_en   = p0_drv;
    assign o_p0_rcv_en   = p0_rcv;
    assign o_p1_tx_data  = p1_tx_data;
    assign o_p1_tx_hs    = p1_tx_hs;
    assign o_p1_drv_en   = p1_drv;
    assign o_p1_rcv_en   = p1_rcv;
    assign o_strap_error = strap_err;
endmodule // rai_isolator

//--- testbench/rai_line_model.sv
// Purpose: far-side transceiver feeding one port receiver
// Assumes: terminated bus
// Notes:   no line delay, so cycle counts stay exact
`timescale 1ns/1ps
module rai_line_model (
    input  wire i_talk,
    input  wire i_level,
    output wire o_data
);
    // a released bus rests high through its termination
    assign o_data = i_talk ? i_level : 1'h1;
endmodule // rai_line_model

//--- testbench/rai_isolator_assertions.sv
// Purpose: port checks for rai_isolator
// Assumes: straps change only in reset
// Notes:   port0 to port1 direction watched
`timescale 1ns/1ps
module rai_isolator_chk (
    input wire i_ref_clk, i_rst, i_mode_strap_a, i_mode_strap_b, i_mode_strap_c,
    input wire i_mode_strap_d, i_mode_strap_e, i_hold_time_strap_p1, i_p0_rx_data,
    input wire i_p0_rx_hs, o_p1_tx_data, o_p1_tx_hs, o_strap_error,
    input wire o_p0_drv_en, o_p1_drv_en, o_p0_rcv_en, o_p1_rcv_en
);
    wire m422 = !i_mode_strap_b;
    wire m2w  = i_mode_strap_a & i_mode_strap_b;
    wire bad  = (i_mode_strap_a & !i_mode_strap_b) | i_mode_strap_c | !i_mode_strap_d
                | i_mode_strap_e;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_tx_start;
        !m422 && !i_p0_rx_data && o_p0_rcv_en;
    endsequence
    sequence s_hold_end;
        !$past(i_p0_rx_data, 251) && $past(i_p0_rx_data, 250);
    endsequence
    a_data_fwd: assert property (
        !m2w && !$past(i_rst) |-> o_p1_tx_data == $past(i_p0_rx_data))
        else $error("data not forwarded");
    a_hs_fwd: assert property (
        m422 && !$past(i_rst) |-> o_p1_tx_hs == $past(i_p0_rx_hs))
        else $error("handshake not forwarded");
    a_all_on: assert property (
        m422 && !$past(i_rst) |-> o_p0_drv_en && o_p1_drv_en && o_p0_rcv_en && o_p1_rcv_en)
        else $error("rs422 enable low");
    a_drv_start: assert property (
        s_tx_start |=> o_p1_drv_en)
        else $error("driver late");
    a_hold_short: assert property (
        $fell(o_p1_drv_en) && !m422 && i_hold_time_strap_p1 && !$past(i_rst) |-> s_hold_end)
        else $error("hold wrong");
    a_drv_reset: assert property (
        $past(i_rst) && !m422 |-> !o_p0_drv_en && !o_p1_drv_en)
        else $error("driver on after reset");
    a_rcv_4w: assert property (
        !m422 && !m2w |-> o_p0_rcv_en && o_p1_rcv_en)
        else $error("receiver off");
    a_rcv_2w: assert property (
        m2w |-> o_p1_rcv_en != o_p1_drv_en)
        else $error("receiver not gated");
    a_strap_flag: assert property (
        !$past(i_rst) |-> o_strap_error == $past(bad))
        else $error("strap flag wrong");
endmodule // rai_isolator_chk
bind rai_isolator rai_isolator_chk chk (.*);

//--- testbench/test_rai_isolator.sv
// Purpose: directed bench for rai_isolator
// Assumes: far side modelled by rai_line_model
// Notes:   hold counts measured from last low sample
`timescale 1ns/1ps
module test_rai_isolator;
    reg        i_ref_clk = 0;
    reg        i_rst     = 1;
    reg  [4:0] strap     = 5'h08;
    reg  [1:0] hold      = 2'h0;
    reg  [1:0] talk      = 2'h0;
    reg  [1:0] lvl       = 2'h3;
    reg  [1:0] hs        = 2'h3;
    wire [1:0] rxd, txd, txh, drv, rcv;
    wire       err;
    integer    failures  = 0;
    integer    n_tests   = 0;
    always #20 i_ref_clk = ~i_ref_clk;
    rai_line_model far0 (.i_talk(talk[0]), .i_level(lvl[0]), .o_data(rxd[0]));
    rai_line_model far1 (.i_talk(talk[1]), .i_level(lvl[1]), .o_data(rxd[1]));
    rai_isolator uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mode_strap_a(strap[0]),
        .i_mode_strap_b(strap[1]), .i_mode_strap_c(strap[2]), .i_mode_strap_d(strap[3]),
        .i_mode_strap_e(strap[4]), .i_hold_time_strap_p0(hold[0]),
        .i_hold_time_strap_p1(hold[1]), .i_p0_rx_data(rxd[0]), .i_p0_rx_hs(hs[0]),
        .i_p1_rx_data(rxd[1]), .i_p1_rx_hs(hs[1]), .o_p0_tx_data(txd[0]), .o_p0_tx_hs(txh[0]),
        .o_p0_drv_en(drv[0]), .o_p0_rcv_en(rcv[0]), .o_p1_tx_data(txd[1]),
        .o_p1_tx_hs(txh[1]), .o_p1_drv_en(drv[1]), .o_p1_rcv_en(rcv[1]), .o_strap_error(err));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task start(input [4:0] s, input [1:0] h);
        begin
            @(posedge i_ref_clk);
            i_rst <= 1;
            strap <= s;
            hold <= h;
            // release every far side so no stale level looks like traffic
            talk <= 2'h0;
            lvl <= 2'h3;
            hs <= 2'h3;
            repeat (20) @(posedge i_ref_clk);
            i_rst <= 0;
            repeat (2) @(posedge i_ref_clk);
            #1;
        end
    endtask
    task fwd(input [1:0] d, input [1:0] h);
        begin
            @(posedge i_ref_clk);
            talk <= 2'h3;
            lvl <= d;
            hs <= h;
            @(posedge i_ref_clk);
            #1;
            check({txd, txh}, {d[0], d[1], h[0], h[1]});
        end
    endtask
    task telegram(input integer p, input integer h);
        integer n;
        begin
            @(posedge i_ref_clk);
            talk[p] <= 1;
            lvl[p] <= 0;
            @(posedge i_ref_clk);
            talk[p] <= 0;
            #1;
            check(drv[1-p], 1);
            check(drv[p], 0);
            check(rcv[1-p], !(strap[0] & strap[1]));
            n = 0;
            while (drv[1-p] === 1'h1 && n < 2000) begin
                @(posedge i_ref_clk);
                #1;
                n = n + 1;
            end
            check(n, h);
            check(rcv[1-p], 1);
        end
    endtask
    task print_verdict;
        begin
            $display("comparisons %0d failures %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        start(5'h08, 2'h0);
        check({drv, rcv, err}, 5'h1E);
        fwd(2'h1, 2'h2);
        fwd(2'h2, 2'h1);
        // short hold suits fast links, long hold slow ones
        start(5'h0A, 2'h2);
        check(drv, 2'h0);
        check(txh, 2'h3);
        telegram(0, 250);
        telegram(1, 1250);
        start(5'h0B, 2'h1);
        telegram(1, 250);
        telegram(0, 1250);
        start(5'h0D, 2'h0);
        check({drv, err}, 3'h7);
        print_verdict;
    end
    initial begin
        // run needs about 3100 cycles
        #400000;
        failures = failures + 1;
        print_verdict;
    end
endmodule // test_rai_isolator
